// ===== lpdcd_pkg.sv
// Purpose: Shared constants for the low-power DRAM command decoder
// Assumes: Six-pin command bus, eight banks, two set points
// Notes:   First-edge codes are on cmd_pin_bus[4:0], with cs high
package lpdcd_pkg;
  // First-edge command codes, pins 4..0
  localparam logic [4:0] CODE_MPC    = 5'h00;
  localparam logic [4:0] CODE_PRE    = 5'h10;
  localparam logic [4:0] CODE_REF    = 5'h08;
  localparam logic [4:0] CODE_SRE    = 5'h18;
  localparam logic [4:0] CODE_WR1    = 5'h04;
  localparam logic [4:0] CODE_SRX    = 5'h14;
  localparam logic [4:0] CODE_MWR1   = 5'h0C;
  localparam logic [4:0] CODE_RD1    = 5'h02;
  localparam logic [4:0] CODE_CAS2   = 5'h12;
  localparam logic [4:0] CODE_MRW1   = 5'h06;
  localparam logic [4:0] CODE_MRW2   = 5'h16;
  localparam logic [4:0] CODE_MRR1   = 5'h0E;
  // Mode register addresses
  localparam logic [5:0] SE_CFG_ADDR = 6'h33;
  localparam logic [5:0] SP_CTL_ADDR = 6'h0D;
  // Field positions
  localparam int SE_RDQS_BIT = 1;
  localparam int SE_WDQS_BIT = 2;
  localparam int SE_CLK_BIT  = 3;
  localparam int SP_WR_BIT   = 6;
  localparam int SP_OP_BIT   = 7;
  localparam int FEAT_SE_BIT = 5;
  // Reset values
  localparam logic [7:0] SE_CFG_RST = 8'h00;
  localparam logic [7:0] SP_CTL_RST = 8'h00;
  // Kinds of decoded command
  typedef enum logic [3:0] {
    LPDCD_K_NONE, LPDCD_K_MPC, LPDCD_K_PRE, LPDCD_K_REF, LPDCD_K_SRE,
    LPDCD_K_SRX, LPDCD_K_WR, LPDCD_K_MWR, LPDCD_K_RD, LPDCD_K_MRW,
    LPDCD_K_MRR, LPDCD_K_ACT, LPDCD_K_CAS, LPDCD_K_ILL
  } lpdcd_kind_t;
endpackage : lpdcd_pkg

// ===== lpdcd_sync.sv
// Purpose: Two-flop level synchroniser into the core clock domain
// Assumes: Input is a slow level
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module lpdcd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff; // First stage only
  logic [W-1:0] q_ff;    // Settled copy

  // Two-flop chain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule : lpdcd_sync

// ===== lpdcd_decoder.sv
// Purpose: Two-edge command decoder with set-point single-ended config
// Assumes: Link clock is free running while commands are sent
// Notes:   Decode runs on the link clock; mode writes cross to core by toggle
`timescale 1ns/10ps
module lpdcd_decoder
  import lpdcd_pkg::*;
#(
  parameter bit SE_SUPPORTED = 1'b1 // Feature advertised in feature reg
) (
  // Core clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Link pins
  input  wire logic       link_clk_i,
  input  wire logic       cs_i,
  input  wire logic [5:0] cmd_pin_bus_i,
  input  wire logic       otf_burst_en_i,
  // Decoded command, link domain
  output logic            cmd_valid_o,
  output lpdcd_kind_t     cmd_kind_o,
  output logic [7:0]      bank_mask_o,
  output logic            auto_precharge_flag_o,
  output logic            burst_32_o,
  output logic [9:0]      column_o,
  output logic [15:0]     row_o,
  output logic [6:0]      mpc_op_o,
  output logic            cmd_error_o,
  // Read strobe complement pin
  output logic            strobe_complement_o,
  output logic            strobe_complement_oe_o,
  // Config state, core domain
  output logic [2:0]      se_mode_o,
  output logic [7:0]      device_feature_reg_o,
  output logic            setpoint_operate_sel_o
);
  // Link-domain reset, released through two flops on the link clock
  logic lrst_m_ff, lrst_ff;
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lrst_m_ff <= 1'b0;
      lrst_ff   <= 1'b0;
    end else begin
      lrst_m_ff <= 1'b1;
      lrst_ff   <= lrst_m_ff;
    end
  end

  // Core-domain reset release copy
  logic crst_m_ff, crst_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crst_m_ff <= 1'b0;
      crst_ff   <= 1'b0;
    end else begin
      crst_m_ff <= 1'b1;
      crst_ff   <= crst_m_ff;
    end
  end

  // Sequencer states; pending second halves
  typedef enum logic [1:0] {LPDCD_IDLE, LPDCD_SECOND} lpdcd_state_t;
  lpdcd_state_t state_ff;     // Current half
  lpdcd_kind_t  kind_ff;      // Kind caught on first edge
  logic [5:0]   first_ff;     // First-edge pins
  logic         cas_ok_ff;    // A column half may follow now
  lpdcd_kind_t  cas_kind_ff;  // What the column half completes
  logic [5:0]   cas_first_ff; // First-edge pins of pending access
  logic [5:0]   cas_r2_ff;    // Second-edge pins of pending access
  logic [1:0]   quiet_ff;     // Deselects still owed after short MULTI_PURPOSE_CMD
  logic         act_wait_ff;  // Activate second half expected

  // Classify a first-edge code
  function automatic lpdcd_kind_t classify(input logic [5:0] p);
    lpdcd_kind_t k;
    k = LPDCD_K_ILL;
    if (p[0]) begin
      k = LPDCD_K_ACT;
    end else begin
      unique case (p[4:0])
        CODE_MPC:  k = LPDCD_K_MPC;
        CODE_PRE:  k = LPDCD_K_PRE;
        CODE_REF:  k = LPDCD_K_REF;
        CODE_SRE:  k = LPDCD_K_SRE;
        CODE_WR1:  k = LPDCD_K_WR;
        CODE_SRX:  k = LPDCD_K_SRX;
        CODE_MWR1: k = LPDCD_K_MWR;
        CODE_RD1:  k = LPDCD_K_RD;
        CODE_CAS2: k = LPDCD_K_CAS;
        CODE_MRW1: k = LPDCD_K_MRW;
        CODE_MRW2: k = LPDCD_K_MRW;
        CODE_MRR1: k = LPDCD_K_MRR;
        default:   k = LPDCD_K_ILL; // Reserved codes
      endcase
    end
    return k;
  endfunction : classify

  // Short MPCs (oscillator, calibration) need no column half
  function automatic logic mpc_needs_cas(input logic [6:0] op);
    return (op[6:4] == 3'h4) && (op[3:0] inside {4'h1, 4'h2, 4'h3});
  endfunction : mpc_needs_cas

  lpdcd_kind_t k_now;
  logic [6:0]  mpc_op_now;
  logic        is_mrw2;
  assign k_now      = classify(cmd_pin_bus_i);
  assign mpc_op_now = {first_ff[5], cmd_pin_bus_i};
  assign is_mrw2    = (first_ff[4:0] == CODE_MRW2);

  // Mode-write first half holds address and high data bit
  logic [5:0] mrw_addr_ff;
  logic       mrw_op7_ff;
  logic       mrw_pend_ff;
  logic       wr_strobe;   // Completed mode write, one link cycle
  logic [5:0] wr_addr;
  logic [7:0] wr_data;

  always_ff @(posedge link_clk_i or negedge lrst_ff) begin
    if (!lrst_ff) begin
      state_ff <= LPDCD_IDLE;
      kind_ff  <= LPDCD_K_NONE;
      first_ff <= 6'h00;
    end else if (state_ff == LPDCD_IDLE) begin
      if (cs_i) begin
        state_ff <= LPDCD_SECOND;
        kind_ff  <= k_now;
        first_ff <= cmd_pin_bus_i;
      end
    end else begin
      // Second edge ignores cs, pins carry operands
      state_ff <= LPDCD_IDLE;
    end
  end

  logic second;
  assign second = (state_ff == LPDCD_SECOND);

  // Pairing tracker for column, activate and MULTI_PURPOSE_CMD halves
  always_ff @(posedge link_clk_i or negedge lrst_ff) begin
    if (!lrst_ff) begin
      cas_ok_ff    <= 1'b0;
      cas_kind_ff  <= LPDCD_K_NONE;
      cas_first_ff <= 6'h00;
      cas_r2_ff    <= 6'h00;
      act_wait_ff  <= 1'b0;
      quiet_ff     <= 2'h0;
    end else if (second) begin
      // column half opens only after access or long MULTI_PURPOSE_CMD first half
      cas_ok_ff    <= (kind_ff inside {LPDCD_K_WR, LPDCD_K_MWR, LPDCD_K_RD,
                       LPDCD_K_MRR}) ||
                      (kind_ff == LPDCD_K_MPC && mpc_needs_cas(mpc_op_now));
      cas_kind_ff  <= kind_ff;
      cas_first_ff <= first_ff;
      cas_r2_ff    <= cmd_pin_bus_i;
      // activate first half arms the second
      act_wait_ff  <= (kind_ff == LPDCD_K_ACT) && !first_ff[1];
      quiet_ff     <= (kind_ff == LPDCD_K_MPC && !mpc_needs_cas(mpc_op_now)) ?
                      2'h2 : 2'h0;
    end else if (cs_i) begin
      // New command starts; column window closes after one
      quiet_ff     <= quiet_ff;
    end else if (quiet_ff != 2'h0) begin
      quiet_ff     <= quiet_ff - 2'h1;
      cas_ok_ff    <= 1'b0;
    end else begin
      cas_ok_ff    <= 1'b0;
    end
  end

  // Mode-write half pairing
  always_ff @(posedge link_clk_i or negedge lrst_ff) begin
    if (!lrst_ff) begin
      mrw_addr_ff <= 6'h00;
      mrw_op7_ff  <= 1'b0;
      mrw_pend_ff <= 1'b0;
    end else if (second) begin
      // first half arms, second half consumes
      mrw_pend_ff <= (kind_ff == LPDCD_K_MRW) && !is_mrw2;
      if (kind_ff == LPDCD_K_MRW && !is_mrw2) begin
        mrw_addr_ff <= cmd_pin_bus_i;
        mrw_op7_ff  <= first_ff[5];
      end
    end
  end

  // commit only after second write half
  assign wr_strobe = second && kind_ff == LPDCD_K_MRW && is_mrw2 && mrw_pend_ff;
  assign wr_addr   = mrw_addr_ff;
  assign wr_data   = {mrw_op7_ff, first_ff[5], cmd_pin_bus_i};

  // Protocol breach detection, judged on the second edge
  logic err_now;
  // masked write needs pin 5 low
  always_comb begin
    err_now = 1'b0;
    if (second) begin
      err_now = (kind_ff == LPDCD_K_ILL) ||
                (kind_ff == LPDCD_K_CAS && !cas_ok_ff) ||
                (kind_ff == LPDCD_K_MWR && first_ff[5]) ||
                (kind_ff == LPDCD_K_MRW && is_mrw2 && !mrw_pend_ff) ||
                (kind_ff == LPDCD_K_ACT && first_ff[1] && !act_wait_ff) ||
                (act_wait_ff && !(kind_ff == LPDCD_K_ACT && first_ff[1])) ||
                (quiet_ff != 2'h0);
    end
  end

  logic err_ff;
  always_ff @(posedge link_clk_i or negedge lrst_ff) begin
    if (!lrst_ff) begin
      err_ff <= 1'b0;
    end else if (err_now) begin
      err_ff <= 1'b1;
    end
  end
  assign cmd_error_o = err_ff;

  // Decoded command outputs, registered on second edge
  always_ff @(posedge link_clk_i or negedge lrst_ff) begin
    if (!lrst_ff) begin
      cmd_valid_o           <= 1'b0;
      cmd_kind_o            <= LPDCD_K_NONE;
      bank_mask_o           <= 8'h00;
      auto_precharge_flag_o <= 1'b0;
      burst_32_o            <= 1'b0;
      column_o              <= 10'h000;
      row_o                 <= 16'h0000;
      mpc_op_o              <= 7'h00;
    end else begin
      cmd_valid_o <= second && !err_now;
      if (second) begin
        cmd_kind_o <= kind_ff;
        // bank field picks one bank; activate second half carries none
        if (kind_ff inside {LPDCD_K_PRE, LPDCD_K_REF, LPDCD_K_WR, LPDCD_K_MWR, LPDCD_K_RD} ||
            (kind_ff == LPDCD_K_ACT && !first_ff[1])) begin
          bank_mask_o <= 8'h01 << cmd_pin_bus_i[2:0];
        end
        if ((kind_ff == LPDCD_K_PRE || kind_ff == LPDCD_K_REF) && first_ff[5]) begin
          bank_mask_o <= 8'hFF;
        end
        if (kind_ff inside {LPDCD_K_WR, LPDCD_K_MWR, LPDCD_K_RD}) begin
          auto_precharge_flag_o <= cmd_pin_bus_i[5];
          // burst size from flag when enabled
          burst_32_o <= otf_burst_en_i && (kind_ff != LPDCD_K_MWR) && first_ff[5];
          column_o[9] <= cmd_pin_bus_i[4];
        end
        if (kind_ff == LPDCD_K_CAS) begin
          cmd_kind_o <= cas_kind_ff;
          bank_mask_o <= 8'h01 << cas_r2_ff[2:0];
          // column bit placement; low bits zero
          column_o <= {cas_r2_ff[4], first_ff[5], cmd_pin_bus_i, 2'b00};
        end
        if (kind_ff == LPDCD_K_ACT) begin
          row_o <= first_ff[1] ? {row_o[15:10], first_ff[5:2], cmd_pin_bus_i[5:0]} :
                                 {first_ff[5:2], cmd_pin_bus_i[5:4], 10'h000};
        end
        if (kind_ff == LPDCD_K_MPC) begin
          mpc_op_o <= mpc_op_now;
        end
      end
    end
  end

  // Write event crosses by toggle with stable data
  logic       wr_tog_ff;
  logic [5:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  always_ff @(posedge link_clk_i or negedge lrst_ff) begin
    if (!lrst_ff) begin
      wr_tog_ff  <= 1'b0;
      wr_addr_ff <= 6'h00;
      wr_data_ff <= 8'h00;
    end else if (wr_strobe) begin
      wr_tog_ff  <= ~wr_tog_ff;
      wr_addr_ff <= wr_addr;
      wr_data_ff <= wr_data;
    end
  end
  // Limitation: writes closer than a few core cycles could be missed

  logic wr_tog_s;
  lpdcd_sync #(.W(1)) u_tog_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (crst_ff),
    .d_i     (wr_tog_ff),
    .q_o     (wr_tog_s)
  );
  logic wr_tog_d_ff;
  logic wr_evt;
  always_ff @(posedge core_clk_i or negedge crst_ff) begin
    if (!crst_ff) begin
      wr_tog_d_ff <= 1'b0;
    end else begin
      wr_tog_d_ff <= wr_tog_s;
    end
  end
  assign wr_evt = wr_tog_s ^ wr_tog_d_ff;

  // Set-point control and two copies of single-ended config
  logic [7:0] sp_ctl_ff;
  logic [7:0] se_cfg_ff [2];
  always_ff @(posedge core_clk_i or negedge crst_ff) begin
    if (!crst_ff) begin
      sp_ctl_ff    <= SP_CTL_RST;
      se_cfg_ff[0] <= SE_CFG_RST;
      se_cfg_ff[1] <= SE_CFG_RST;
    end else if (wr_evt) begin
      if (wr_addr_ff == SP_CTL_ADDR) begin
        sp_ctl_ff <= wr_data_ff;
      end
      // write only the selected set point
      if (wr_addr_ff == SE_CFG_ADDR) begin
        se_cfg_ff[sp_ctl_ff[SP_WR_BIT]] <= wr_data_ff & 8'h0E;
      end
    end
  end

  // operate from the active set point
  logic [7:0] se_act;
  assign se_act = se_cfg_ff[sp_ctl_ff[SP_OP_BIT]];
  // modes exposed for the pad logic
  assign se_mode_o = {se_act[SE_CLK_BIT], se_act[SE_WDQS_BIT], se_act[SE_RDQS_BIT]};
  assign setpoint_operate_sel_o = sp_ctl_ff[SP_OP_BIT];
  assign device_feature_reg_o = {2'b00, SE_SUPPORTED, 5'h00} & (8'h01 << FEAT_SE_BIT);

  always_ff @(posedge core_clk_i or negedge crst_ff) begin
    if (!crst_ff) begin
      strobe_complement_oe_o <= 1'b1;
      strobe_complement_o    <= 1'b0;
    end else begin
      strobe_complement_oe_o <= !se_act[SE_RDQS_BIT];
      strobe_complement_o    <= 1'b0;
    end
  end

  // Checks
  se_rdqs_hiz_a: assert property (@(posedge core_clk_i) disable iff (!crst_ff)
    se_act[SE_RDQS_BIT] |=> !strobe_complement_oe_o) else $error("rdqs comp driven");
  mrw_commit_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    wr_strobe |=> (wr_tog_ff != $past(wr_tog_ff)) && (wr_addr_ff == $past(mrw_addr_ff)))
    else $error("mode write lost");
  all_bank_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    (second && kind_ff == LPDCD_K_PRE && first_ff[5]) |=> bank_mask_o == 8'hFF)
    else $error("all bank miss");
  bank_sel_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    (second && kind_ff == LPDCD_K_PRE && !first_ff[5]) |=>
    bank_mask_o == (8'h01 << $past(cmd_pin_bus_i[2:0]))) else $error("bank wrong");
  frame_two_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    (!second && cs_i) |=> second ##1 !second) else $error("frame length");
  col_low_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    (second && kind_ff == LPDCD_K_CAS && cas_ok_ff) |=>
    (column_o[1:0] == 2'b00) && (column_o[7:2] == $past(cmd_pin_bus_i)))
    else $error("column bits");
  mwr_pin5_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    (second && kind_ff == LPDCD_K_MWR && first_ff[5]) |=> cmd_error_o)
    else $error("mwr pin5 unflagged");
  err_sticky_a: assert property (@(posedge link_clk_i) disable iff (!lrst_ff)
    cmd_error_o |=> cmd_error_o) else $error("error cleared");
endmodule : lpdcd_decoder

// ===== lpdcd_host.sv
// Purpose: Host controller model driving the two-edge command bus
// Assumes: Link clock runs free; the bench orders the commands
// Notes:   Released pins show the inverse of their last value
`timescale 1ns/10ps
module lpdcd_host (
  // Link clock
  input  wire logic       link_clk_i,
  // Command pins
  output logic            cs_o,
  output logic [5:0]      cmd_pin_bus_o
);
  // Idle bus at time zero
  initial begin
    cs_o          = 1'h0;
    cmd_pin_bus_o = 6'h00;
  end

  // no clock-gate or write strobe pins; both taken as valid
  // One raw cycle, launched just after the edge
  task automatic cyc(input logic c, input logic [5:0] p);
    @(posedge link_clk_i);
    #1;
    cs_o          = c;
    cmd_pin_bus_o = p;
  endtask : cyc

  task automatic frame(input logic [5:0] r1, input logic [5:0] r2);
    cyc(1'h1, r1);
    cyc(1'h0, r2);
  endtask : frame

  // deselects, pins released
  // Inverting each cycle so a stale operand is never mistaken for data
  task automatic idle(input int n);
    repeat (n) cyc(1'h0, ~cmd_pin_bus_o);
  endtask : idle
endmodule : lpdcd_host

// ===== testbench.sv
// Purpose: Self-checking bench for the two-edge command decoder
// Assumes: On-the-fly burst length enabled until one late case, then off to the end
// Notes:   Protocol breaches are sticky, so each one runs after a reset
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import lpdcd_pkg::*;
  // One ordinary command and what it should decode to
  typedef struct {
    logic [5:0]  a1, a2, b1, b2; // Both frames, pins per edge
    logic        two;            // Second frame follows at once
    lpdcd_kind_t kind;
    logic [7:0]  mask;
    logic        ap, b32;
    logic [9:0]  col;
    logic [15:0] row;
    logic [6:0]  op;
  } lpdcd_row_t;

  logic          core_clk_i  = 1'h0;   // Core clock, 4 ns
  logic          link_clk_i  = 1'h0;   // Link clock, 48 ns
  logic          rst_n_i     = 1'h0;   // Async reset, low active
  logic          otf_burst_en_i = 1'h1; // Enable, held high until the late burst case clears it
  logic          cs_i;
  logic [5:0]    cmd_pin_bus_i;
  logic          cmd_valid_o, auto_precharge_flag_o, burst_32_o, cmd_error_o;
  lpdcd_kind_t   cmd_kind_o;
  logic [7:0]    bank_mask_o, device_feature_reg_o;
  logic [9:0]    column_o;
  logic [15:0]   row_o;
  logic [6:0]    mpc_op_o;
  logic          strobe_complement_o, strobe_complement_oe_o, setpoint_operate_sel_o;
  logic [2:0]    se_mode_o;
  int            num_errors, check_count, nvalid, v0, cycles;
  lpdcd_row_t    rows [13];
  logic [6:0]    errs [7][4];         // Raw {cs, pins} cycles
  logic [6:0]    quiet = 7'h45;       // Cases that must give no valid

  // Clocks; the link starts offset so edges do not line up
  always #2 core_clk_i = ~core_clk_i;
  initial begin
    #5;
    forever #24 link_clk_i = ~link_clk_i;
  end

  lpdcd_host u_lpdcd_host (.link_clk_i(link_clk_i), .cs_o(cs_i), .cmd_pin_bus_o(cmd_pin_bus_i));

  lpdcd_decoder u_lpdcd_decoder (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .cs_i(cs_i),
    .cmd_pin_bus_i(cmd_pin_bus_i), .otf_burst_en_i(otf_burst_en_i),
    .cmd_valid_o(cmd_valid_o), .cmd_kind_o(cmd_kind_o), .bank_mask_o(bank_mask_o),
    .auto_precharge_flag_o(auto_precharge_flag_o), .burst_32_o(burst_32_o),
    .column_o(column_o), .row_o(row_o), .mpc_op_o(mpc_op_o), .cmd_error_o(cmd_error_o),
    .strobe_complement_o(strobe_complement_o),
    .strobe_complement_oe_o(strobe_complement_oe_o), .se_mode_o(se_mode_o),
    .device_feature_reg_o(device_feature_reg_o),
    .setpoint_operate_sel_o(setpoint_operate_sel_o));

  // Count decoded commands; the pulse lasts one link cycle
  always @(negedge link_clk_i) begin
    if (cmd_valid_o === 1'h1) begin
      nvalid++;
    end
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Hang guard, far above the few thousand cycles needed
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  // Long enough for three edges of the slow link clock
  task automatic do_reset();
    @(posedge core_clk_i);
    #1;
    rst_n_i = 1'h0;
    repeat (40) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'h1;
    repeat (4) @(posedge link_clk_i);
  endtask : do_reset

  task automatic mode_reg_write(input logic [5:0] ma, input logic [7:0] d);
    u_lpdcd_host.frame({d[7], CODE_MRW1}, ma);
    u_lpdcd_host.frame({d[6], CODE_MRW2}, d[5:0]);
    u_lpdcd_host.idle(6);
  endtask : mode_reg_write

  initial begin
    // masked write row keeps pin 5 low and burst 16
    rows = '{
      '{6'h10, 6'h05, 6'h00, 6'h00, 1'h0, LPDCD_K_PRE, 8'h20, 1'h0, 1'h0, 10'h000, 16'h0, 7'h0},
      '{6'h30, 6'h03, 6'h00, 6'h00, 1'h0, LPDCD_K_PRE, 8'hFF, 1'h0, 1'h0, 10'h000, 16'h0, 7'h0},
      '{6'h08, 6'h07, 6'h00, 6'h00, 1'h0, LPDCD_K_REF, 8'h80, 1'h0, 1'h0, 10'h000, 16'h0, 7'h0},
      '{6'h28, 6'h00, 6'h00, 6'h00, 1'h0, LPDCD_K_REF, 8'hFF, 1'h0, 1'h0, 10'h000, 16'h0, 7'h0},
      '{6'h18, 6'h00, 6'h00, 6'h00, 1'h0, LPDCD_K_SRE, 8'h00, 1'h0, 1'h0, 10'h000, 16'h0, 7'h0},
      '{6'h14, 6'h00, 6'h00, 6'h00, 1'h0, LPDCD_K_SRX, 8'h00, 1'h0, 1'h0, 10'h000, 16'h0, 7'h0},
      '{6'h24, 6'h32, 6'h32, 6'h28, 1'h1, LPDCD_K_WR, 8'h04, 1'h1, 1'h1, 10'h3A0, 16'h0, 7'h0},
      '{6'h02, 6'h01, 6'h12, 6'h3F, 1'h1, LPDCD_K_RD, 8'h02, 1'h0, 1'h0, 10'h0FC, 16'h0, 7'h0},
      '{6'h0C, 6'h27, 6'h32, 6'h14, 1'h1, LPDCD_K_MWR, 8'h80, 1'h1, 1'h0, 10'h150, 16'h0, 7'h0},
      '{6'h29, 6'h13, 6'h1F, 6'h05, 1'h1, LPDCD_K_ACT, 8'h08, 1'h0, 1'h0, 10'h0, 16'hA5C5, 7'h0},
      '{6'h20, 6'h0D, 6'h00, 6'h00, 1'h0, LPDCD_K_MPC, 8'h00, 1'h0, 1'h0, 10'h0, 16'h0, 7'h4D},
      '{6'h20, 6'h03, 6'h12, 6'h00, 1'h1, LPDCD_K_MPC, 8'h00, 1'h0, 1'h0, 10'h0, 16'h0, 7'h43},
      '{6'h0E, 6'h33, 6'h12, 6'h00, 1'h1, LPDCD_K_MRR, 8'h00, 1'h0, 1'h0, 10'h0, 16'h0, 7'h0}};
    // Orphan column, masked write pin high, orphan mode write, broken
    // activate, command in the quiet gap, late column, reserved code
    errs = '{'{7'h52, 7'h00, 7'h00, 7'h00}, '{7'h6C, 7'h00, 7'h52, 7'h00},
             '{7'h76, 7'h0E, 7'h00, 7'h00}, '{7'h41, 7'h00, 7'h00, 7'h41},
             '{7'h60, 7'h0D, 7'h48, 7'h00}, '{7'h44, 7'h00, 7'h00, 7'h52},
             '{7'h5C, 7'h00, 7'h00, 7'h00}};
    do_reset();
    `CHK("valid", 1'h0, cmd_valid_o)
    `CHK("error", 1'h0, cmd_error_o)
    `CHK("rdqsb_oe", 1'h1, strobe_complement_oe_o)
    `CHK("se_mode", 3'h0, se_mode_o)
    `CHK("feature", 1'h1, device_feature_reg_o[FEAT_SE_BIT])
    // Ordinary commands, each followed by released-bus deselects
    foreach (rows[i]) begin
      v0 = nvalid;
      u_lpdcd_host.frame(rows[i].a1, rows[i].a2);
      if (rows[i].two) u_lpdcd_host.frame(rows[i].b1, rows[i].b2);
      u_lpdcd_host.idle(4);
      `CHK("valid", 1'h1, nvalid != v0)
      `CHK("kind", rows[i].kind, cmd_kind_o)
      if (rows[i].kind inside {LPDCD_K_WR, LPDCD_K_RD, LPDCD_K_MWR}) begin
        `CHK("ap", rows[i].ap, auto_precharge_flag_o)
        `CHK("burst", rows[i].b32, burst_32_o)
        `CHK("column", rows[i].col, column_o)
      end
      if (!(rows[i].kind inside {LPDCD_K_SRE, LPDCD_K_SRX, LPDCD_K_MPC, LPDCD_K_MRR}))
        `CHK("bank", rows[i].mask, bank_mask_o)
      if (rows[i].kind == LPDCD_K_ACT) `CHK("row", rows[i].row, row_o)
      if (rows[i].kind == LPDCD_K_MPC) `CHK("mpc", rows[i].op, mpc_op_o)
    end
    `CHK("error", 1'h0, cmd_error_o)
    // Single-ended config in both set points
    mode_reg_write(SE_CFG_ADDR, 8'h0E);
    `CHK("se_mode", 3'h7, se_mode_o)
    `CHK("rdqsb_oe", 1'h0, strobe_complement_oe_o)
    `CHK("rdqsb", 1'h0, strobe_complement_o)
    mode_reg_write(SP_CTL_ADDR, 8'h40);
    mode_reg_write(SE_CFG_ADDR, 8'h02);
    `CHK("se_mode", 3'h7, se_mode_o)
    mode_reg_write(SP_CTL_ADDR, 8'hC0);
    `CHK("op_sel", 1'h1, setpoint_operate_sel_o)
    `CHK("se_mode", 3'h1, se_mode_o)
    mode_reg_write(SP_CTL_ADDR, 8'h00);
    `CHK("se_mode", 3'h7, se_mode_o)
    // Burst flag ignored with on-the-fly burst off
    otf_burst_en_i = 1'h0;
    u_lpdcd_host.frame(rows[6].a1, rows[6].a2);
    u_lpdcd_host.frame(rows[6].b1, rows[6].b2);
    u_lpdcd_host.idle(4);
    `CHK("burst", 1'h0, burst_32_o)
    `CHK("column", rows[6].col, column_o)
    // Protocol breaches, one per reset
    foreach (errs[i]) begin
      do_reset();
      v0 = nvalid;
      for (int k = 0; k < 4; k++) u_lpdcd_host.cyc(errs[i][k][6], errs[i][k][5:0]);
      u_lpdcd_host.idle(6);
      `CHK("error", 1'h1, cmd_error_o)
      if (quiet[i]) `CHK("valid", 1'h0, nvalid != v0)
      `CHK("se_mode", 3'h0, se_mode_o)
    end
    results();
  end
endmodule : testbench
